// File: bmwd_defs.svh
`ifndef BMWD_DEFS_SVH
`define BMWD_DEFS_SVH

// configuration offsets (byte addresses, 16-bit registers)
`define BMWD_OFS_NP_LOW     8'h20
`define BMWD_OFS_NP_HIGH    8'h22
`define BMWD_OFS_PF_LOW     8'h24
`define BMWD_OFS_PF_HIGH    8'h26

// field layout
`define BMWD_FIELD_MSB      15
`define BMWD_FIELD_LSB      4
`define BMWD_FIELD_W        12
`define BMWD_ADDR_MSB       31
`define BMWD_ADDR_LSB       20

// reset values
`define BMWD_LOW_RESET      16'hFFF0
`define BMWD_HIGH_RESET     16'h0000
`define BMWD_LOW_FIELD_RST  12'hFFF
`define BMWD_HIGH_FIELD_RST 12'h000
`define BMWD_RSVD_ZERO      4'h0
`define BMWD_RD_NONE        16'h0000

`endif

// File: bmwd_pkg.sv
`default_nettype none
package bmwd_pkg;

  // configuration access from the host side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } bmwd_cfg_req_t;

  // processor memory access to be decoded
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } bmwd_mem_req_t;

  // decode result
  typedef struct packed {
    logic valid;
    logic hit_np;
    logic hit_pf;
    logic fwd;
  } bmwd_route_t;

  typedef enum logic [1:0] {
    BMWD_WIN_NP = 2'h1,
    BMWD_WIN_PF = 2'h2
  } bmwd_win_t;

endpackage
`default_nettype wire

// File: bmwd_window.sv
`timescale 1ns/100ps
`default_nettype none
`include "bmwd_defs.svh"

// one address window: holds base/limit fields and compares A[31:20]
module bmwd_window #(
  parameter int FW = `BMWD_FIELD_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // field writes
  input  wire logic          low_we,
  input  wire logic          high_we,
  input  wire logic [FW-1:0] wfield,
  // compare
  input  wire logic [FW-1:0] addr_hi,
  output logic      [FW-1:0] low_field,
  output logic      [FW-1:0] high_field,
  output logic               hit
);

  // reset values and compare are built for the register field width
  if (FW != `BMWD_FIELD_W) begin : g_bad_fw
    $error("window field width must match the register field");
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_field <= `BMWD_LOW_FIELD_RST;
    end else if (low_we) begin
      low_field <= wfield;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      high_field <= `BMWD_HIGH_FIELD_RST;
    end else if (high_we) begin
      high_field <= wfield;
    end
  end

  // base bits 19:0 as zero and limit bits as ones reduce to a field compare;
  // base above limit therefore matches nothing without a special case
  assign hit = (addr_hi >= low_field) && (addr_hi <= high_field);

endmodule
`default_nettype wire

// File: bmwd_bridge_memory_window_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "bmwd_defs.svh"

module bmwd_bridge_memory_window_decode
  import bmwd_pkg::*;
(
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESETN,
  // configuration access
  input  wire bmwd_pkg::bmwd_cfg_req_t CFG_REQ,
  output logic                         CFG_RVALID,
  output logic [15:0]                  CFG_RDATA,
  // processor memory access
  input  wire bmwd_pkg::bmwd_mem_req_t MEM_REQ,
  // routing decision, one cycle after the request
  output bmwd_pkg::bmwd_route_t        ROUTE
);

  import bmwd_pkg::*;

  localparam int FW    = `BMWD_FIELD_W;
  localparam int NWIN  = 2;
  localparam int RSVDW = `BMWD_FIELD_LSB;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the field must cover the register bits above the reserved nibble
  if (`BMWD_FIELD_MSB - `BMWD_FIELD_LSB + 1 != FW) begin : g_bad_field
    $error("register field layout does not match the field width");
  end

  // the compared address slice must be exactly as wide as a field
  if (`BMWD_ADDR_MSB - `BMWD_ADDR_LSB + 1 != FW) begin : g_bad_addr
    $error("compared address slice does not match the field width");
  end

  // the tied nibble must fill the bits below the field exactly
  if ($bits(`BMWD_RSVD_ZERO) != RSVDW) begin : g_bad_rsvd
    $error("reserved nibble width does not match the field position");
  end

  // reset words and reset fields are kept in two forms; they must agree
  if (`BMWD_LOW_RESET != {`BMWD_LOW_FIELD_RST, `BMWD_RSVD_ZERO}) begin : g_bad_low_rst
    $error("base reset word does not match the base reset field");
  end

  if (`BMWD_HIGH_RESET != {`BMWD_HIGH_FIELD_RST, `BMWD_RSVD_ZERO}) begin : g_bad_high_rst
    $error("limit reset word does not match the limit reset field");
  end

  // each register is a 16-bit word on an even byte offset
  if (`BMWD_OFS_NP_LOW % 2 != 0 || `BMWD_OFS_NP_HIGH % 2 != 0 ||
      `BMWD_OFS_PF_LOW % 2 != 0 || `BMWD_OFS_PF_HIGH % 2 != 0) begin : g_bad_ofs
    $error("register offsets must be even");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register select

  logic cfg_wr;
  logic cfg_rd;
  logic sel_np_low;
  logic sel_np_high;
  logic sel_pf_low;
  logic sel_pf_high;
  logic sel_any;

  // both strobes may stand together; the read then returns the old word
  assign cfg_wr = CFG_REQ.wr;
  assign cfg_rd = CFG_REQ.rd;

  // exact byte-address match; odd offsets and neighbours select nothing
  assign sel_np_low  = (CFG_REQ.addr == `BMWD_OFS_NP_LOW);
  assign sel_np_high = (CFG_REQ.addr == `BMWD_OFS_NP_HIGH);
  assign sel_pf_low  = (CFG_REQ.addr == `BMWD_OFS_PF_LOW);
  assign sel_pf_high = (CFG_REQ.addr == `BMWD_OFS_PF_HIGH);
  assign sel_any     = sel_np_low | sel_np_high | sel_pf_low | sel_pf_high;

  ////////////////////////////////////////////////////////////////////////////
  // write path

  logic [NWIN-1:0] low_we;
  logic [NWIN-1:0] high_we;
  logic [FW-1:0]   low_field  [NWIN];
  logic [FW-1:0]   high_field [NWIN];
  logic [NWIN-1:0] hit;
  logic [FW-1:0]   addr_hi;
  logic [FW-1:0]   old_field;
  logic [FW-1:0]   merged;

  assign addr_hi = MEM_REQ.addr[`BMWD_ADDR_MSB:`BMWD_ADDR_LSB];

  // window 0 is the non-prefetchable pair, window 1 the prefetchable pair
  assign low_we[0]  = cfg_wr & sel_np_low;
  assign high_we[0] = cfg_wr & sel_np_high;
  assign low_we[1]  = cfg_wr & sel_pf_low;
  assign high_we[1] = cfg_wr & sel_pf_high;

  // field being written, so that a lane left alone keeps its bits
  always_comb begin
    old_field = 12'h000;
    if (sel_np_low) begin
      old_field = low_field[0];
    end else if (sel_np_high) begin
      old_field = high_field[0];
    end else if (sel_pf_low) begin
      old_field = low_field[1];
    end else if (sel_pf_high) begin
      old_field = high_field[1];
    end
  end

  // merge byte enables with the old field; written bits 3:0 are dropped
  always_comb begin
    merged[11:4] = CFG_REQ.be[1] ? CFG_REQ.wdata[15:8] : old_field[11:4];
    merged[3:0]  = CFG_REQ.be[0] ? CFG_REQ.wdata[7:4]  : old_field[3:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two windows

  genvar gi;
  generate
    for (gi = 0; gi < NWIN; gi++) begin : g_win
      bmwd_window #(
        .FW (FW)
      ) u_win (
        .clk        (CLK),
        .resetn     (RESETN),
        .low_we     (low_we[gi]),
        .high_we    (high_we[gi]),
        .wfield     (merged),
        .addr_hi    (addr_hi),
        .low_field  (low_field[gi]),
        .high_field (high_field[gi]),
        .hit        (hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration read-back

  logic [15:0] low_word  [NWIN];
  logic [15:0] high_word [NWIN];
  logic [15:0] next_rdata;

  // reserved nibble is tied, so a write to it can never show on read-back
  for (genvar gw = 0; gw < NWIN; gw++) begin : g_word
    assign low_word[gw]  = {low_field[gw],  `BMWD_RSVD_ZERO};
    assign high_word[gw] = {high_field[gw], `BMWD_RSVD_ZERO};
  end

  always_comb begin
    next_rdata = `BMWD_RD_NONE;
    if (sel_np_low) begin
      next_rdata = low_word[0];
    end else if (sel_np_high) begin
      next_rdata = high_word[0];
    end else if (sel_pf_low) begin
      next_rdata = low_word[1];
    end else if (sel_pf_high) begin
      next_rdata = high_word[1];
    end
  end

  // every read is answered, unmapped offsets too, so a host never waits
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= cfg_rd;
    end
  end

  // data rests at zero between reads so a stale word never looks valid
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CFG_RDATA <= `BMWD_RD_NONE;
    end else if (cfg_rd && sel_any) begin
      CFG_RDATA <= next_rdata;
    end else begin
      CFG_RDATA <= `BMWD_RD_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing decision

  bmwd_route_t next_route;

  // overlap is not checked; both hit flags may rise together
  always_comb begin
    next_route        = '0;
    next_route.valid  = MEM_REQ.valid;
    next_route.hit_np = MEM_REQ.valid & hit[0];
    next_route.hit_pf = MEM_REQ.valid & hit[1];
    next_route.fwd    = MEM_REQ.valid & (hit[0] | hit[1]);
  end

  // registered so the graphics side sees a clean one-cycle pulse
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ROUTE <= '0;
    end else begin
      ROUTE <= next_route;
    end
  end

endmodule
`default_nettype wire

// File: bmwd_chk.sv
`timescale 1ns/100ps
`default_nettype none
module bmwd_chk
  import bmwd_pkg::*;
(
  // watched ports
  input wire logic                    CLK,
  input wire logic                    RESETN,
  input wire bmwd_pkg::bmwd_cfg_req_t CFG_REQ,
  input wire logic                    CFG_RVALID,
  input wire logic [15:0]             CFG_RDATA,
  input wire bmwd_pkg::bmwd_mem_req_t MEM_REQ,
  input wire bmwd_pkg::bmwd_route_t   ROUTE
);
  logic wrote;
  logic mapped;
  assign mapped = CFG_REQ.addr inside {8'h20, 8'h22, 8'h24, 8'h26};
  // fields are known to be at reset values until the first write
  always_ff @(posedge CLK) wrote <= RESETN & (wrote | CFG_REQ.wr);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_rd_answer: assert property (CFG_REQ.rd |=> CFG_RVALID)
    else $error("read not answered next cycle");
  chk_rd_quiet: assert property (!CFG_REQ.rd |=> !CFG_RVALID && CFG_RDATA == 16'h0000)
    else $error("read data without a read");
  chk_low_bits: assert property (CFG_RVALID |-> CFG_RDATA[3:0] == 4'h0)
    else $error("low nibble not zero");
  chk_unmapped_zero: assert property (CFG_REQ.rd && !mapped |=> CFG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_route_answer: assert property (MEM_REQ.valid |=> ROUTE.valid)
    else $error("decode not answered next cycle");
  chk_route_quiet: assert property (!MEM_REQ.valid |=> ROUTE == '0)
    else $error("route without access");
  chk_fwd_either: assert property (ROUTE.valid |-> ROUTE.fwd == (ROUTE.hit_np | ROUTE.hit_pf))
    else $error("forward not the union of hits");
  chk_reset_miss: assert property (!wrote && !CFG_REQ.wr |=> !ROUTE.hit_np && !ROUTE.hit_pf)
    else $error("hit with reset windows");
endmodule
bind bmwd_bridge_memory_window_decode bmwd_chk u_chk (.CLK(CLK), .RESETN(RESETN),
  .CFG_REQ(CFG_REQ), .CFG_RVALID(CFG_RVALID), .CFG_RDATA(CFG_RDATA),
  .MEM_REQ(MEM_REQ), .ROUTE(ROUTE));
`default_nettype wire

// File: bmwd_gfx_sink.sv
`timescale 1ns/100ps
`default_nettype none
// graphics side: only counts what is forwarded to it
module bmwd_gfx_sink
  import bmwd_pkg::*;
(
  input wire logic                  CLK,
  input wire bmwd_pkg::bmwd_route_t ROUTE,
  output var int                    fwd_count
);
  initial fwd_count = 0;
  always @(posedge CLK) if (ROUTE.fwd) fwd_count <= fwd_count + 1;
endmodule
`default_nettype wire

// File: bmwd_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bmwd_bridge_memory_window_decode_tb;
  import bmwd_pkg::*;
  logic          CLK = 1'b0;
  logic          RESETN = 1'b0;
  bmwd_cfg_req_t CFG_REQ = '0;
  bmwd_mem_req_t MEM_REQ = '0;
  logic          CFG_RVALID;
  logic [15:0]   CFG_RDATA;
  bmwd_route_t   ROUTE;
  int            fwd_count;
  int            bad_count = 0;
  int            n_compared = 0;
  always #50 CLK = ~CLK;
  bmwd_bridge_memory_window_decode u_dut (.CLK(CLK), .RESETN(RESETN), .CFG_REQ(CFG_REQ),
    .CFG_RVALID(CFG_RVALID), .CFG_RDATA(CFG_RDATA), .MEM_REQ(MEM_REQ), .ROUTE(ROUTE));
  bmwd_gfx_sink u_sink (.CLK(CLK), .ROUTE(ROUTE), .fwd_count(fwd_count));
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle request, answer sampled after the next edge lands
  task automatic cfg(input logic w, input logic [7:0] a, input logic [1:0] b,
                     input logic [15:0] d);
    @(posedge CLK) CFG_REQ <= '{w, !w, a, b, d};
    @(posedge CLK) CFG_REQ <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    cfg(1'b0, a, 2'h0, 16'h0000);
    check("cfg read", {CFG_RVALID, CFG_RDATA}, {1'b1, e});
  endtask
  task automatic mem(input logic [31:0] a, input logic np, input logic pf);
    @(posedge CLK) MEM_REQ <= '{1'b1, a};
    @(posedge CLK) MEM_REQ <= '0;
    #1;
    check("route", 17'(ROUTE), {13'h0000, 1'b1, np, pf, np | pf});
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    rd(8'h20, 16'hFFF0);
    rd(8'h22, 16'h0000);
    rd(8'h24, 16'hFFF0);
    rd(8'h26, 16'h0000);
    mem(32'hFFF00000, 1'b0, 1'b0);
    // windows set up first, kept apart from each other
    cfg(1'b1, 8'h20, 2'h3, 16'h1234);
    cfg(1'b1, 8'h22, 2'h3, 16'h1FFF);
    cfg(1'b1, 8'h24, 2'h3, 16'h8000);
    cfg(1'b1, 8'h26, 2'h3, 16'h80F0);
    cfg(1'b1, 8'h28, 2'h3, 16'hFFFF);
    rd(8'h20, 16'h1230);
    rd(8'h22, 16'h1FF0);
    rd(8'h26, 16'h80F0);
    rd(8'h28, 16'h0000);
    mem(32'h12300000, 1'b1, 1'b0);
    mem(32'h122FFFFF, 1'b0, 1'b0);
    mem(32'h1FFFFFFF, 1'b1, 1'b0);
    mem(32'h20000000, 1'b0, 1'b0);
    mem(32'h80000000, 1'b0, 1'b1);
    mem(32'h80FFFFFF, 1'b0, 1'b1);
    mem(32'h81000000, 1'b0, 1'b0);
    check("forwarded", 17'(fwd_count), 17'h00004);
    cfg(1'b1, 8'h20, 2'h1, 16'hFFFF);
    rd(8'h20, 16'h12F0);
    cfg(1'b1, 8'h24, 2'h2, 16'h9999);
    rd(8'h24, 16'h9900);
    // reset in mid-run must bring back the reset words and empty windows
    @(posedge CLK) RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    rd(8'h20, 16'hFFF0);
    rd(8'h22, 16'h0000);
    mem(32'h12300000, 1'b0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
